// ### bsc_buck34_startup_config_reg.sv
/*
 * APB register bank holding the start-up slot and voltage of bucks 3 and 4,
 * with the decoded settings and start requests the sequencer consumes.
 * Assumes the sequencer drives the reached timeslot and both hardware enables
 * synchronously to ref_clk.
 * Assumes an APB master that keeps each request steady until pready is seen.
 * The decoded outputs trail the stored register by one clock, so the
 * sequencer must not act on them in the cycle right after a write.
 */
// Chosen here: the APB register port.
module bsc_buck34_startup_config_reg
	import bsc_pkg::*;
#(
	parameter int ADDR_W = 20
) (
	input wire logic ref_clk, // 125 MHz clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error, unmapped address.
	input wire logic [2:0] seq_timeslot, // Highest timeslot reached, 0 for none.
	input wire logic hw_enable1, // Hardware enable input 1.
	input wire logic hw_enable2, // Hardware enable input 2.
	output bsc_buck_cfg_t buck3_cfg, // Decoded buck 3 settings.
	output bsc_buck_cfg_t buck4_cfg, // Decoded buck 4 settings.
	output logic buck3_start, // Buck 3 start request.
	output logic buck4_start // Buck 4 start request.
);

	// Turns a slot field and a voltage field into the converter settings.
	function automatic bsc_buck_cfg_t decode_cfg(input logic [2:0] slot, input logic [4:0] vfield);
		bsc_buck_cfg_t c;
		logic [6:0] code;
		c = '0;
		code = {vfield, 2'h0};
		c.voltage_code = code;
		c.off = (slot == BSC_SLOT_OFF);
		c.hw_en1_sel = (slot == BSC_SLOT_HW1);
		c.hw_en2_sel = (slot == BSC_SLOT_HW2);
		if (slot != BSC_SLOT_OFF && slot <= BSC_SLOT_LAST) begin
			c.slot_onehot = 5'(5'h01 << (slot - 3'h1));
		end
		if (code >= BSC_CODE_SAT) begin
			c.voltage_mv = BSC_MV_MAX;
		end else begin
			c.voltage_mv = 12'(BSC_MV_BASE + BSC_MV_STEP * {5'h00, code});
		end
		return c;
	endfunction : decode_cfg

	// Start request: timeslot reached, or the chosen hardware enable is high.
	function automatic logic start_req(input logic [2:0] slot, input logic [2:0] reached,
		input logic en1, input logic en2);
		logic s;
		s = 1'b0;
		if (slot == BSC_SLOT_HW1) begin
			s = en1;
		end else if (slot == BSC_SLOT_HW2) begin
			s = en2;
		end else if (slot != BSC_SLOT_OFF) begin
			s = (reached >= slot);
		end
		return s;
	endfunction : start_req

	// The stored configuration word and its next value.
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;

	// Bus answer registers and their next values.
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// Decoded settings and start requests and their next values.
	bsc_buck_cfg_t b3_r;
	bsc_buck_cfg_t b3_nxt;
	bsc_buck_cfg_t b4_r;
	bsc_buck_cfg_t b4_nxt;
	logic b3_start_r;
	logic b3_start_nxt;
	logic b4_start_r;
	logic b4_start_nxt;

	// Bus qualifiers and the fields picked out of the stored word.
	logic hit;
	logic setup_phase;
	logic write_commit;
	logic [2:0] b4_slot;
	logic [2:0] b3_slot;
	logic [4:0] b4_vfield;
	logic [4:0] b3_vfield;

	// Every address bit is compared, so aliases further up the map answer
	// with an error instead of silently reaching the register.
	assign hit = (paddr == BSC_CFG_ADDR[ADDR_W-1:0]);

	// The answer is prepared only in a setup cycle.
	assign setup_phase = psel && !penable;

	// A write commits only in the access cycle this block marks ready, so a
	// master that lingers in the access phase never writes twice.
	assign write_commit = psel && penable && pready_r && pwrite && hit;

	// Field slices of the stored word.
	assign b4_slot = cfg_r[BSC_B4_SLOT_LSB +: BSC_SLOT_W];
	assign b3_slot = cfg_r[BSC_B3_SLOT_LSB +: BSC_SLOT_W];
	assign b4_vfield = cfg_r[BSC_B4_VOLT_LSB +: BSC_VFIELD_W];
	assign b3_vfield = cfg_r[BSC_B3_VOLT_LSB +: BSC_VFIELD_W];

	// Bus side: answer every access in its first access cycle, so no wait
	// states; read data and error are prepared during the setup cycle.
	always_comb begin
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		pready_nxt = setup_phase;
		if (setup_phase) begin
			pslverr_nxt = !hit;
			if (hit && !pwrite) begin
				prdata_nxt = {16'h0000, cfg_r};
			end else begin
				prdata_nxt = 32'h0000_0000;
			end
		end
	end

	// Bus answer registers; ready is a one-cycle pulse per transfer.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'h0;
			pslverr_r <= 1'h0;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// field write.
	// Only byte lanes 0 and 1 carry register bits; the upper lanes are
	// ignored, and a write with no strobes leaves the register unchanged.
	always_comb begin
		cfg_nxt = cfg_r;
		if (write_commit) begin
			if (pstrb[0]) begin
				cfg_nxt[7:0] = pwdata[7:0];
			end
			if (pstrb[1]) begin
				cfg_nxt[15:8] = pwdata[15:8];
			end
		end
	end

	// reset to zero.
	// The stored word; its reset value leaves both converters off.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= BSC_CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Decode side: outputs lag the register by one clock, which keeps every
	// output straight from a flip-flop at the cost of that latency.
	always_comb begin
		b4_nxt = decode_cfg(b4_slot, b4_vfield);
		b3_nxt = decode_cfg(b3_slot, b3_vfield);
		b4_start_nxt = start_req(b4_slot, seq_timeslot, hw_enable1, hw_enable2);
		b3_start_nxt = start_req(b3_slot, seq_timeslot, hw_enable1, hw_enable2);
	end

	// Decoded settings; during reset they read all zero, then show the
	// decode of the reset value one clock after release.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			b3_r <= '0;
			b4_r <= '0;
			b3_start_r <= 1'h0;
			b4_start_r <= 1'h0;
		end else begin
			b3_r <= b3_nxt;
			b4_r <= b4_nxt;
			b3_start_r <= b3_start_nxt;
			b4_start_r <= b4_start_nxt;
		end
	end

	// Every output is a register copy.
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign buck3_cfg = b3_r;
	assign buck4_cfg = b4_r;
	assign buck3_start = b3_start_r;
	assign buck4_start = b4_start_r;

endmodule : bsc_buck34_startup_config_reg

// ### bsc_buck34_startup_config_reg_test.sv
/* Bench for the buck 3/4 start-up register over APB.
Assumes zero-wait APB and outputs one cycle after the register. */
module bsc_buck34_startup_config_reg_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bsc_pkg::*;
	logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, hw_enable1 = 1, hw_enable2 = 0;
	logic pready, pslverr, err, buck3_start, buck4_start;
	logic [19:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 0;
	logic [2:0] seq_timeslot = 0, k;
	logic [4:0] v, w;
	bsc_buck_cfg_t buck3_cfg, buck4_cfg;
	int fails = 0, check_count = 0;
	bsc_buck34_startup_config_reg bsc_buck34_startup_config_reg_inst (.*);
	initial forever #4 ref_clk = ~ref_clk;
	task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	// One APB transfer, then an idle edge so calls never meet at one edge.
	task automatic apb(logic wr, logic [19:0] a, logic [31:0] d, logic [3:0] s);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask : apb
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// Slot decode as {off, slots 1-5, enable 1, enable 2}.
	function automatic logic [7:0] dec(logic [2:0] s);
		return s == 3'h0 ? 8'h80 : s > 3'h5 ? {6'h00, s == 3'h6, s == 3'h7} : {1'h0, 5'h01 << (s - 3'h1), 2'h0};
	endfunction : dec
	function automatic logic [11:0] mv(logic [4:0] f);
		return f < 5'h1A ? 12'h352 + 12'h064 * f : 12'hD48;
	endfunction : mv
	// Watchdog far beyond the expected run.
	initial begin
		#100000;
		fails++;
		finish_test();
	end
	// Reset state, every slot code, voltages across saturation, refusals.
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		apb(0, BSC_CFG_ADDR, 0, 0);
		check("reset", {rd, buck3_cfg.off, buck4_cfg.off}, 32'h3);
		for (int s = 0; s < 8; s++) begin
			k = s[2:0];
			v = 5'h16 + {2'h0, k};
			w = 5'h1D - {2'h0, k};
			apb(1, BSC_CFG_ADDR, {16'hFFFF, k, w, k, v}, 4'hF);
			apb(0, BSC_CFG_ADDR, 0, 0);
			check("readback", rd, {16'h0, k, w, k, v});
			check("b4 slot", {buck4_cfg.off, buck4_cfg.slot_onehot, buck4_cfg.hw_en1_sel, buck4_cfg.hw_en2_sel}, dec(k));
			check("b3 slot", {buck3_cfg.off, buck3_cfg.slot_onehot, buck3_cfg.hw_en1_sel, buck3_cfg.hw_en2_sel}, dec(k));
			check("start", {buck3_start, buck4_start}, {2{k == 3'h6}});
			check("b4 mv", buck4_cfg.voltage_mv, mv(w));
			check("b3 mv", {buck3_cfg.voltage_mv, buck3_cfg.voltage_code}, {mv(v), v, 2'h0});
		end
		apb(1, BSC_CFG_ADDR + 20'h4, 0, 4'hF);
		check("error", err, 1'h1);
		apb(1, BSC_CFG_ADDR, 0, 0);
		apb(0, BSC_CFG_ADDR, 0, 0);
		check("kept", rd, 32'hF6FD);
		// Timeslot compare and hardware enable 2 with buck 4 at saturation.
		seq_timeslot <= 3'h4;
		hw_enable2 <= 1'h1;
		apb(1, BSC_CFG_ADDR, {16'h0, 3'h3, 5'h1A, 3'h7, 5'h19}, 4'h3);
		apb(0, BSC_CFG_ADDR, 0, 0);
		check("start on", {buck3_start, buck4_start}, 2'h3);
		check("sat", buck4_cfg.voltage_mv, 12'hD48);
		seq_timeslot <= 3'h2;
		hw_enable2 <= 1'h0;
		repeat (2) @(posedge ref_clk);
		check("start off", {buck3_start, buck4_start}, 2'h0);
		resetn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (2) @(posedge ref_clk);
		check("reset again", {buck3_cfg.off, buck4_cfg.off, buck4_cfg.voltage_code}, 9'h180);
		finish_test();
	end
endmodule : bsc_buck34_startup_config_reg_test

// ### bsc_cfg_properties.sv
/* Assertions for the buck 3/4 start-up register.
Assumes the ports of bsc_buck34_startup_config_reg. */
module bsc_cfg_properties
	import bsc_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic resetn, // Reset.
	input wire logic penable, // Access.
	input wire logic pwrite, // Write.
	input wire logic [19:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Data.
	input wire logic [3:0] pstrb, // Strobes.
	input wire logic pready, // Ready.
	input wire bsc_buck_cfg_t buck3_cfg, // Buck 3.
	input wire bsc_buck_cfg_t buck4_cfg // Buck 4.
);
	logic wr;
	// A completed write to the register.
	assign wr = penable && pready && pwrite && paddr == BSC_CFG_ADDR;
	// Saturating millivolt scale.
	function automatic logic [11:0] mv(logic [6:0] c);
		return c < 7'h66 ? 12'h352 + 12'h019 * c : 12'hD48;
	endfunction : mv
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_b4_dec; $past(resetn) |-> $onehot({buck4_cfg.off, buck4_cfg.slot_onehot, buck4_cfg.hw_en1_sel, buck4_cfg.hw_en2_sel}); endproperty
	a_b4_dec: assert property (p_b4_dec) else $error("buck 4 slot decode");
	property p_b3_dec; $past(resetn) |-> $onehot({buck3_cfg.off, buck3_cfg.slot_onehot, buck3_cfg.hw_en1_sel, buck3_cfg.hw_en2_sel}); endproperty
	a_b3_dec: assert property (p_b3_dec) else $error("buck 3 slot decode");
	property p_b4_wr; wr && pstrb[1] |-> ##2 buck4_cfg.voltage_code == {$past(pwdata[12:8], 2), 2'h0}; endproperty
	a_b4_wr: assert property (p_b4_wr) else $error("buck 4 code");
	property p_b3_wr; wr && pstrb[0] |-> ##2 buck3_cfg.voltage_code == {$past(pwdata[4:0], 2), 2'h0}; endproperty
	a_b3_wr: assert property (p_b3_wr) else $error("buck 3 code");
	property p_b4_mv; $past(resetn) |-> buck4_cfg.voltage_mv == mv(buck4_cfg.voltage_code); endproperty
	a_b4_mv: assert property (p_b4_mv) else $error("buck 4 millivolts");
	property p_b3_mv; $past(resetn) |-> buck3_cfg.voltage_mv == mv(buck3_cfg.voltage_code); endproperty
	a_b3_mv: assert property (p_b3_mv) else $error("buck 3 millivolts");
	property p_rst; $past(resetn) && !$past(resetn, 2) |-> buck3_cfg.off && buck4_cfg.off; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule : bsc_cfg_properties
bind bsc_buck34_startup_config_reg bsc_cfg_properties u_chk (.*);

// ### bsc_pkg.sv
/*
 * Constants and types for the buck 3/4 start-up configuration register bank.
 * Assumes one APB slave with 32-bit data and a single clock domain.
 */
// Operation
// - Buck 4 slot: 000 off, 001-101 timeslots 1-5, 110/111 hardware enables.
// - Buck 3 slot uses the same encoding as buck 4.
// - Buck 4 voltage field sits in bits 12:8, holding code bits 6:2.
// - Buck 4 code: 0.85 V at 00h, 25 mV steps, 66h-7Fh give 3.4 V.
// - Buck 3 voltage field sits in bits 4:0, holding code bits 6:2.
// - Buck 3 code: 0.85 V at 00h, 25 mV steps, 66h-7Fh give 3.4 V.
package bsc_pkg;

	// Register index; the byte address is four times the index.
	localparam logic [19:0] BSC_CFG_INDEX = 20'h07812;
	localparam logic [19:0] BSC_CFG_ADDR = {BSC_CFG_INDEX[17:0], 2'h0};
	localparam int BSC_REG_W = 16;
	localparam logic [15:0] BSC_CFG_RESET = 16'h0000;

	// Field positions.
	localparam int BSC_B4_SLOT_LSB = 13;
	localparam int BSC_B4_VOLT_LSB = 8;
	localparam int BSC_B3_SLOT_LSB = 5;
	localparam int BSC_B3_VOLT_LSB = 0;
	localparam int BSC_SLOT_W = 3;
	localparam int BSC_VFIELD_W = 5;
	localparam int BSC_CODE_W = 7;
	localparam int BSC_CODE_DROP = 2;

	// Slot encodings.
	localparam logic [2:0] BSC_SLOT_OFF = 3'h0;
	localparam logic [2:0] BSC_SLOT_LAST = 3'h5;
	localparam logic [2:0] BSC_SLOT_HW1 = 3'h6;
	localparam logic [2:0] BSC_SLOT_HW2 = 3'h7;
	localparam int BSC_NUM_SLOTS = 5;

	// Voltage scale in millivolts.
	localparam logic [11:0] BSC_MV_BASE = 12'h352;
	localparam logic [11:0] BSC_MV_STEP = 12'h019;
	localparam logic [11:0] BSC_MV_MAX = 12'hD48;
	localparam logic [6:0] BSC_CODE_SAT = 7'h66;

	// Decoded start-up settings for one converter.
	typedef struct packed {
		logic off;
		logic [4:0] slot_onehot;
		logic hw_en1_sel;
		logic hw_en2_sel;
		logic [6:0] voltage_code;
		logic [11:0] voltage_mv;
	} bsc_buck_cfg_t;

endpackage : bsc_pkg
